// file: logic/pin_sync.sv
// two-flop synchroniser with edge outputs for the control pins
module pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // raw pins, resting levels that gate the fall outputs
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] rest_i,
  // synchronised level and falling edge
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_r;   // first stage, read only by stage two
  logic [WIDTH-1:0] sync_r;   // second stage
  logic [WIDTH-1:0] prev_r;   // delayed copy for edge detect
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;
  logic [WIDTH-1:0] prev_nxt;

  // next values: straight shift
  always_comb
  begin
    meta_nxt = pin_i;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // registers come out of reset high: both pins idle inactive high
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= {WIDTH{1'b1}};
      sync_r <= {WIDTH{1'b1}};
      prev_r <= {WIDTH{1'b1}};
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // falls are reported only for pins whose resting level is high
  assign level_o = sync_r;
  assign fall_o  = prev_r & ~sync_r & rest_i;

endmodule

// file: logic/sar_adc_parallel_control.sv
// start-of-conversion, busy and tri-state result control of a 16-bit converter
// How it works
// - result bus released when deselected, converting
// - chip select fall with convert starts conversion
// - busy low from start until finish
// - result driven one margin before busy rises
// - selects still low after window restart
// - convert fall under chip select starts too
// - bus driven when read selected, idle
// - early deselect keeps bus off, read later
// - last result retained for later reads
// - completion returns sampler to acquire
// - result in two's complement coding
module sar_adc_parallel_control #(
  parameter int unsigned CONV_CYCLES    = sar_ctl_pkg::CONV_CYCLES,
  parameter int unsigned MARGIN_CYCLES  = sar_ctl_pkg::MARGIN_CYCLES,
  parameter int unsigned RESTART_CYCLES = sar_ctl_pkg::RESTART_CYCLES
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // control pins from the controller
  input  wire logic        cs_n_i,
  input  wire logic        rd_conv_i,
  // sample word from the quantiser, two's complement
  input  wire logic [15:0] sample_i,
  // status toward the controller
  output logic             busy_n_o,
  // sample-and-hold steering, high while sampling
  output logic             track_o,
  // result bus pins, split into level and enable
  output logic [15:0]      result_o,
  output logic [15:0]      result_oe_o
);

  sar_ctl_pkg::ctl_pins_type   pins_lvl;   // synchronised pin levels
  sar_ctl_pkg::ctl_pins_type   pins_fall;  // synchronised falling edges
  sar_ctl_pkg::result_bus_type bus;        // bus being built

  sar_ctl_pkg::conv_state_type state_r;    // sequencer state
  sar_ctl_pkg::conv_state_type state_nxt;
  logic [sar_ctl_pkg::CNT_W-1:0] cnt_r;    // conversion and window timer
  logic [sar_ctl_pkg::CNT_W-1:0] cnt_nxt;
  logic [15:0]                   result_r; // retained result word
  logic [15:0]                   result_nxt;
  logic [15:0]                   dout_r;   // registered bus level
  logic [15:0]                   dout_nxt;
  logic                          oe_r;     // registered bus enable
  logic                          oe_nxt;
  logic                          busy_n_r; // registered busy
  logic                          busy_n_nxt;
  logic                          track_r;  // registered sampler steer
  logic                          track_nxt;
  logic                          start;    // conversion trigger
  logic                          read_sel; // read selected on the pins

  // both pins pass two flops before anything reads them
  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({cs_n_i, rd_conv_i}),
    .rest_i  (2'h3),
    .level_o (pins_lvl),
    .fall_o  (pins_fall)
  );

  // start decode: either pin falling while the other is low
  always_comb
  begin
    start = 1'b0;
    // chip select falls with convert selected
    if (pins_fall.cs_n && !pins_lvl.rd_conv)
    begin
      start = 1'b1;
    end
    // convert falls with chip select already low; noisy but legal
    else if (pins_fall.rd_conv && !pins_lvl.cs_n)
    begin
      start = 1'b1;
    end
    read_sel = !pins_lvl.cs_n && pins_lvl.rd_conv;
  end

  // sequencer next state; an edge inside a conversion is dropped
  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    result_nxt = result_r;
    busy_n_nxt = busy_n_r;
    track_nxt  = track_r;
    case (state_r)
      // acquiring, waiting for a start
      sar_ctl_pkg::ST_IDLE:
      begin
        if (start)
        begin
          state_nxt  = sar_ctl_pkg::ST_CONVERT;
          cnt_nxt    = sar_ctl_pkg::CNT_W'(CONV_CYCLES - MARGIN_CYCLES - 1);
          busy_n_nxt = 1'b0;
          track_nxt  = 1'b0; // hold the sample
        end
      end
      // bit trials run; bus stays released, edges ignored
      sar_ctl_pkg::ST_CONVERT:
      begin
        if (cnt_r == '0)
        begin
          state_nxt  = sar_ctl_pkg::ST_PRESENT;
          cnt_nxt    = sar_ctl_pkg::CNT_W'(MARGIN_CYCLES - 1);
          result_nxt = sample_i;
        end
        else
        begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      // result stands on the bus ahead of busy rising
      sar_ctl_pkg::ST_PRESENT:
      begin
        if (cnt_r == '0)
        begin
          state_nxt  = sar_ctl_pkg::ST_WINDOW;
          cnt_nxt    = sar_ctl_pkg::CNT_W'(RESTART_CYCLES - 1);
          busy_n_nxt = 1'b1;
          track_nxt  = 1'b1;
        end
        else
        begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      // grace window after busy rises
      sar_ctl_pkg::ST_WINDOW:
      begin
        if (start)
        begin
          state_nxt  = sar_ctl_pkg::ST_CONVERT;
          cnt_nxt    = sar_ctl_pkg::CNT_W'(CONV_CYCLES - MARGIN_CYCLES - 1);
          busy_n_nxt = 1'b0;
          track_nxt  = 1'b0;
        end
        else if (cnt_r == '0)
        begin
          // both selects still low: restart without a new select edge
          if (!pins_lvl.cs_n && !pins_lvl.rd_conv)
          begin
            state_nxt  = sar_ctl_pkg::ST_CONVERT;
            cnt_nxt    = sar_ctl_pkg::CNT_W'(CONV_CYCLES - MARGIN_CYCLES - 1);
            busy_n_nxt = 1'b0;
            track_nxt  = 1'b0;
          end
          else
          begin
            state_nxt = sar_ctl_pkg::ST_IDLE;
          end
        end
        else
        begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default:
      begin
        state_nxt = sar_ctl_pkg::ST_IDLE;
      end
    endcase
  end

  // bus next values: drive only when read selected and not converting
  always_comb
  begin
    oe_nxt   = 1'b0;
    dout_nxt = dout_r;
    // last trial edge: open the bus with the new word, a full cycle
    // ahead of busy rising, so the lead never collapses to zero
    if (state_r == sar_ctl_pkg::ST_CONVERT && cnt_r == '0)
    begin
      oe_nxt   = read_sel;
      dout_nxt = sample_i;
    end
    // present stage keeps the freshly loaded word ahead of busy
    else if (state_r == sar_ctl_pkg::ST_PRESENT)
    begin
      oe_nxt   = read_sel;
      dout_nxt = result_r;
    end
    // outside a conversion the retained word can be read any time
    else if (state_r != sar_ctl_pkg::ST_CONVERT && !start)
    begin
      oe_nxt   = read_sel;
      dout_nxt = result_r;
    end
    // a deselect mid-conversion simply leaves read_sel low here
    // so the bus stays off at completion and opens on a later read
  end

  // sequencer and bus registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r  <= sar_ctl_pkg::ST_IDLE;
      cnt_r    <= '0;
      result_r <= sar_ctl_pkg::RESULT_RST;
      dout_r   <= sar_ctl_pkg::RESULT_RST;
      oe_r     <= 1'b0;
      busy_n_r <= 1'b1;
      track_r  <= 1'b1;
    end
    else
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      result_r <= result_nxt;
      dout_r   <= dout_nxt;
      oe_r     <= oe_nxt;
      busy_n_r <= busy_n_nxt;
      track_r  <= track_nxt;
    end
  end

  // bus is one enable fanned to all sixteen bits; word passed as-is
  always_comb
  begin
    bus.data = dout_r;
    bus.oe   = {16{oe_r}};
  end

  assign result_o    = bus.data;
  assign result_oe_o = bus.oe;
  assign busy_n_o    = busy_n_r;
  assign track_o     = track_r;

endmodule

// file: logic/sar_ctl_pkg.sv
// shared constants and carrier types for the converter control block
package sar_ctl_pkg;

  // clock rate in kHz and the derived period
  localparam int unsigned CLK_KHZ          = 25000;
  localparam int unsigned CLK_PERIOD_NS    = 1000000 / CLK_KHZ;

  // result width and coding
  localparam int unsigned RESULT_W         = 16;
  localparam logic [15:0] RESULT_RST       = 16'h0000;
  localparam logic [15:0] RESULT_POS_FULL  = 16'h7FFF;
  localparam logic [15:0] RESULT_NEG_FULL  = 16'h8000;

  // conversion time, typical, in ns; count of cycles rounds down
  localparam int unsigned CONV_TIME_NS     = 3300;
  localparam int unsigned CONV_CYCLES      = CONV_TIME_NS / CLK_PERIOD_NS;
  // data valid ahead of done, least 25 ns: rounds up to whole cycles
  localparam int unsigned DATA_TO_DONE_MARGIN_NS = 25;
  localparam int unsigned MARGIN_CYCLES    =
    (DATA_TO_DONE_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // window after done within which both selects low restart, 250 ns
  localparam int unsigned RESTART_WIN_NS   = 250;
  localparam int unsigned RESTART_CYCLES   = RESTART_WIN_NS / CLK_PERIOD_NS;
  // counter width for the timers
  localparam int unsigned CNT_W            = 8;

  // synchronised control pins
  typedef struct packed {
    logic cs_n;
    logic rd_conv;
  } ctl_pins_type;

  // tri-state result bus toward the pins
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] oe;
  } result_bus_type;

  // conversion sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_CONVERT = 4'h2,
    ST_PRESENT = 4'h4,
    ST_WINDOW  = 4'h8
  } conv_state_type;

endpackage

// file: testbench/sar_ctl_chk.sv
// port checker for busy, sampler steer and result bus
module sar_ctl_chk #(
  parameter int unsigned CONV_CYCLES = 8
) (
  // all ports of the control block
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        cs_n_i,
  input wire logic        rd_conv_i,
  input wire logic [15:0] sample_i,
  input wire logic        busy_n_o,
  input wire logic        track_o,
  input wire logic [15:0] result_o,
  input wire logic [15:0] result_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] low_r;   // edges with busy low
  logic [7:0] low_nxt; // cleared while busy high
  // busy-low length counter
  always_comb
    low_nxt = busy_n_o ? 8'h00 : low_r + 8'h01;
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      low_r <= 8'h00;
    else
      low_r <= low_nxt;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_oe_uniform: assert property (result_oe_o == 16'h0000 || result_oe_o == 16'hFFFF)
    else $error("enable bits differ");
  a_desel_off: assert property (cs_n_i [*6] |-> result_oe_o == 16'h0000)
    else $error("bus driven while deselected");
  a_conv_off: assert property ((!rd_conv_i) [*6] |-> result_oe_o == 16'h0000)
    else $error("bus driven under convert select");
  a_busy_off: assert property ($fell(busy_n_o) |-> (result_oe_o == 16'h0000) [*6])
    else $error("bus driven while converting");
  a_start_busy: assert property (($fell(cs_n_i) && !rd_conv_i && busy_n_o) ##1
    (!cs_n_i && !rd_conv_i) [*3] |-> ##[1:2] !busy_n_o)
    else $error("start not answered by busy");
  a_busy_len: assert property ($rose(busy_n_o) |-> low_r == CONV_CYCLES)
    else $error("busy low length wrong");
  a_oe_lead: assert property ($rose(busy_n_o) && result_oe_o != 16'h0000
    |-> $past(result_oe_o) == 16'hFFFF)
    else $error("data not ahead of busy rise");
  a_restart_now: assert property ($rose(busy_n_o) ##0 (!cs_n_i && !rd_conv_i) [*8]
    |-> ##[0:4] !busy_n_o)
    else $error("no back-to-back conversion");
  a_read_on: assert property ((!cs_n_i && rd_conv_i && busy_n_o) [*6]
    |-> result_oe_o == 16'hFFFF)
    else $error("read select not driving bus");
  a_result_hold: assert property (!$stable(result_o) |-> !busy_n_o)
    else $error("result moved outside conversion");
  a_track_busy: assert property (busy_n_o != $past(busy_n_o) |-> track_o == busy_n_o)
    else $error("sampler steer out of step");
endmodule
bind sar_adc_parallel_control sar_ctl_chk #(.CONV_CYCLES(CONV_CYCLES)) i_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .rd_conv_i(rd_conv_i),
  .sample_i(sample_i), .busy_n_o(busy_n_o), .track_o(track_o),
  .result_o(result_o), .result_oe_o(result_oe_o));

// file: testbench/sar_ctl_host.sv
// controller model: drives the selects, latches result words
module sar_ctl_host (
  // clock and device side
  input  wire logic        clock_i,
  input  wire logic        busy_n_i,
  input  wire logic [15:0] bus_i,
  // selects toward the device
  output logic             cs_n_o,
  output logic             rd_conv_o,
  // captured word and its one-cycle strobe
  output logic             got_o,
  output logic [15:0]      word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q = 1'b1; // busy at the previous edge
  logic take   = 1'b0; // capture request from grab
  initial
  begin
    cs_n_o    = 1'b1;
    rd_conv_o = 1'b1;
    got_o     = 1'b0;
    word_o    = 16'h0000;
  end
  // latch on busy rise under read select, or on request
  always @(posedge clock_i)
  begin
    busy_q <= busy_n_i;
    got_o  <= take || (busy_n_i && !busy_q && !cs_n_o && rd_conv_o);
    word_o <= bus_i;
  end
  // set both selects just after an edge, hold them n edges
  task automatic drive(input logic c, input logic r, input int n);
    @(posedge clock_i);
    #1;
    cs_n_o    = c;
    rd_conv_o = r;
    repeat (n - 1) @(posedge clock_i);
  endtask
  // one-cycle capture of the pins as they stand
  task automatic grab();
    @(posedge clock_i);
    #1 take = 1'b1;
    @(posedge clock_i);
    #1 take = 1'b0;
  endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the converter control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV = 8; // shortened conversion
  logic        clock_i;
  logic        rst_n_i;
  logic        cs_n;        // chip select from the model
  logic        rd_conv;     // read or convert select
  logic        busy_n_o;
  logic        track_o;
  logic        got;         // model captured a word
  logic [15:0] sample_i;
  logic [15:0] result_o;
  logic [15:0] result_oe_o;
  logic [15:0] bus;         // pins as the model sees them
  logic [15:0] word;
  logic [15:0] v;
  logic [15:0] exp_q[$];    // awaited words, oldest first
  logic [15:0] codes [3] = '{sar_ctl_pkg::RESULT_POS_FULL, sar_ctl_pkg::RESULT_RST,
                             sar_ctl_pkg::RESULT_NEG_FULL};
  int          n_fail = 0;
  int          total_checks = 0;
  int          seed = 31457;
  // released pins show the inverse, so a stale value never passes
  assign bus = (result_o & result_oe_o) | (~result_o & ~result_oe_o);
  sar_adc_parallel_control #(.CONV_CYCLES(CONV)) i_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .rd_conv_i(rd_conv),
    .sample_i(sample_i), .busy_n_o(busy_n_o), .track_o(track_o),
    .result_o(result_o), .result_oe_o(result_oe_o));
  sar_ctl_host i_host (
    .clock_i(clock_i), .busy_n_i(busy_n_o), .bus_i(bus), .cs_n_o(cs_n),
    .rd_conv_o(rd_conv), .got_o(got), .word_o(word));
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 300 && busy_n_o !== lvl; i++)
      @(posedge clock_i) #1;
    if (busy_n_o !== lvl)
    begin
      n_fail++;
      finish_test();
    end
  endtask
  // acquisition gap, convert select first, then final levels
  task automatic start(input logic c, input logic r);
    i_host.drive(1'b1, 1'b1, 100);
    i_host.drive(1'b1, 1'b0, 3);
    i_host.drive(1'b0, 1'b0, 4);
    i_host.drive(c, r, 1);
  endtask
  // full read cycle under read select
  task automatic read_word();
    i_host.drive(1'b0, 1'b1, 6);
    i_host.grab();
    i_host.drive(1'b1, 1'b1, 1);
  endtask
  // monitor: each captured word against the oldest note
  always @(posedge clock_i)
    if (got === 1'b1)
      check(word, exp_q.size() > 0 ? exp_q.pop_front() : ~word);
  initial
  begin
    int k;
    rst_n_i  = 1'b0;
    sample_i = 16'h0000;
    repeat (4) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    // full-scale and zero codes then random words; even runs read at finish
    for (k = 0; k < 6; k++)
    begin
      v = k < 3 ? codes[k] : 16'($random(seed));
      sample_i = v;
      if (!k[0])
        exp_q.push_back(v);
      start(k[0], 1'b1);
      wait_busy(1'b0);
      wait_busy(1'b1);
      if (k[0])
        check(result_oe_o, 16'h0000);
      sample_i = ~v; // a newer word must not leak out
      exp_q.push_back(v);
      read_word();
      $display("conversion %0d done", k);
    end
    // convert select falling under chip select also starts
    exp_q.push_back(~v);
    i_host.drive(1'b0, 1'b1, 100);
    i_host.drive(1'b0, 1'b0, 4);
    i_host.drive(1'b1, 1'b1, 1);
    wait_busy(1'b0);
    check({15'h0000, track_o}, 16'h0000);
    wait_busy(1'b1);
    check({15'h0000, track_o}, 16'h0001);
    read_word();
    $display("late convert select done");
    // both selects left low: a second conversion follows
    start(1'b0, 1'b0);
    wait_busy(1'b0);
    wait_busy(1'b1);
    i_host.drive(1'b0, 1'b0, 12);
    #1 check({15'h0000, busy_n_o}, 16'h0000);
    i_host.drive(1'b1, 1'b1, 1);
    wait_busy(1'b1);
    check(16'(exp_q.size()), 16'h0000);
    $display("back-to-back conversion done");
    finish_test();
  end
endmodule
